// ### src/apio_axis_pins.sv
// Axis pin block: sensor inputs, general I/O, physical position counter,
// direction/pulse/not-arrived outputs, sync trigger, register port and IRQ.
// Assumes one sys_clk domain at 200 MHz; motion core supplies motion status.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "apio_map.svh"

// Contract
// [R1] Origin sensor is active while its pin is low.
// [R2] Plus hard limit is active while its pin is low.
// [R3] Minus hard limit is active while its pin is low.
// [R4] Each low general input reads as one in its input status bit.
// [R5] General outputs follow command bits unless inverted or given another function.
// [R6] Position counts once on each rising edge of the count clock.
// [R7] Count direction low adds one, high subtracts one.
// [R8] Direction out low for clockwise, high counter-clockwise, unless inverted.
// [R9] Pulse output stays low while the axis is stopped.
// [R10] Port-2 outputs follow port-2 control bits unless inverted.
// [R11] Not-arrived output high exactly while not-arrived state holds.
// [R12] A falling edge on the trigger pin registers one sync trigger.
// [R13] Outside party supplies the 48 MHz core clock; this block runs on sys_clk, which the bench drives at 200 MHz.
// [R14] Pulling the reset pin low resets the device.
// [R15] Position is 24-bit signed, -8388608 to +8388607.
// [R16] All asynchronous pins are synchronised before level or edge detection.
module apio_axis_pins #(
    parameter int POS_W = `APIO_POS_W,
    parameter int NGEN  = `APIO_NGEN
) (
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire apio_pkg::apio_bus_req_t busReq,
    output logic      [31:0]           rdData,
    input  wire logic                  origin_sensor_n,
    input  wire logic                  plus_limit_sensor_n,
    input  wire logic                  minus_limit_sensor_n,
    input  wire logic [NGEN-1:0]       axis_gen_input_n,
    input  wire logic                  position_count_clock,
    input  wire logic                  position_count_direction,
    input  wire logic                  sync_trigger_n,
    input  wire apio_pkg::apio_motion_t motion,
    input  wire logic [NGEN-1:0]       altFuncSel,
    input  wire logic [NGEN-1:0]       altFuncVal,
    output var apio_pkg::apio_outs_t   pinsOut,
    output logic                       syncTrigPulse,
    output logic                       irq
);
    import apio_pkg::*;

    localparam int NSYNC = 7 + NGEN;

    typedef struct packed {
        logic [POS_W-1:0]         pos;
        logic                     prevCountClk;
        logic                     prevTrig;
        logic [7:0]               trigCount;
        logic                     trigPulse;
        logic [`APIO_NEVT-1:0]    status;
        logic [`APIO_NEVT-1:0]    mask;
        logic [NGEN-1:0]          comOut;
        logic [NGEN-1:0]          comInv;
        logic [NGEN-1:0]          p2Out;
        logic [NGEN-1:0]          p2Inv;
        logic [1:0]               opt;
        logic [2:0]               prevSensors;
        logic                     prevDona;
        logic [31:0]              rd;
        apio_outs_t               outs;
    } apio_state_t;

    apio_state_t st_q;
    apio_state_t st_d;
    apio_pins_t  pins;
    logic [NSYNC-1:0] syncVec;

    // Synchronise every outside pin; active-low idle high, clock/dir idle low [R16]
    apio_sync #(
        .WIDTH (NSYNC),
        .RST   ({{(4 + NGEN){1'b1}}, 2'b00, 1'b1})
    ) u_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .asyncIn ({origin_sensor_n, plus_limit_sensor_n, minus_limit_sensor_n, sync_trigger_n,
                   axis_gen_input_n, position_count_clock, position_count_direction, 1'b1}),
        .syncOut (syncVec)
    );

    // Convert pin levels to active-high meanings
    always_comb
    begin
        pins.origin     = ~syncVec[NSYNC-1];                 // [R1]
        pins.plusLimit  = ~syncVec[NSYNC-2];                 // [R2]
        pins.minusLimit = ~syncVec[NSYNC-3];                 // [R3]
        pins.trig       = ~syncVec[NSYNC-4];
        pins.genIn      = ~syncVec[NGEN+2:3];                // [R4]
        pins.countClk   = syncVec[2];
        pins.countDir   = syncVec[1];
    end

    logic              countEdge;
    logic              trigEdge;
    logic [POS_W-1:0]  posNext;
    logic              posWrap;
    logic [2:0]        sensNow;
    logic [`APIO_NEVT-1:0] evts;
    logic [`APIO_NEVT-1:0] rdClr;

    // Next-state logic for the whole block
    always_comb
    begin
        st_d = st_q;
        sensNow = {pins.minusLimit, pins.plusLimit, pins.origin};
        countEdge = pins.countClk & ~st_q.prevCountClk;      // [R6]
        trigEdge  = pins.trig & ~st_q.prevTrig;              // [R12]
        // Up on low direction, down on high; wraps inside 24-bit two's complement
        posNext = pins.countDir ? st_q.pos - 1'b1 : st_q.pos + 1'b1; // [R7] [R15]
        posWrap = countEdge & (pins.countDir ? (st_q.pos == {1'b1, {(POS_W-1){1'b0}}})
                                             : (st_q.pos == {1'b0, {(POS_W-1){1'b1}}}));
        st_d.prevCountClk = pins.countClk;
        st_d.prevTrig     = pins.trig;
        st_d.prevSensors  = sensNow;
        st_d.prevDona     = motion.notArrived;
        st_d.trigPulse    = trigEdge;
        if (trigEdge)
        begin
            st_d.trigCount = st_q.trigCount + 8'h01;
        end
        if (countEdge)
        begin
            st_d.pos = posNext;                              // [R6]
        end

        // Register writes; a position-load write loses to nothing but a count edge
        if (busReq.wr)
        begin
            case (busReq.addr)
                `APIO_ADR_MASK:   st_d.mask = busReq.wdata[`APIO_NEVT-1:0];
                `APIO_ADR_COM:
                begin
                    st_d.comOut = busReq.wdata[NGEN-1:0];
                    st_d.comInv = busReq.wdata[NGEN+7:8];
                end
                `APIO_ADR_P2C:
                begin
                    st_d.p2Out = busReq.wdata[NGEN-1:0];
                    st_d.p2Inv = busReq.wdata[NGEN+7:8];
                end
                `APIO_ADR_OPT:    st_d.opt = busReq.wdata[1:0];
                `APIO_ADR_POS:    if (!countEdge) st_d.pos = busReq.wdata[POS_W-1:0];
                default:          ;
            endcase
        end

        // Events: sensor assert edges, trigger, wrap, not-arrived entry
        evts = '0;
        evts[`APIO_EVT_ORIGIN] = sensNow[0] & ~st_q.prevSensors[0];
        evts[`APIO_EVT_PLUS]   = sensNow[1] & ~st_q.prevSensors[1];
        evts[`APIO_EVT_MINUS]  = sensNow[2] & ~st_q.prevSensors[2];
        evts[`APIO_EVT_TRIG]   = trigEdge;
        evts[`APIO_EVT_WRAP]   = posWrap;
        evts[`APIO_EVT_NOT_ARRIVED]   = motion.notArrived & ~st_q.prevDona;
        rdClr = (busReq.rd && busReq.addr == `APIO_ADR_STATUS) ? '1 : '0;
        // Set wins over read-clear so no event is lost
        st_d.status = (st_q.status & ~rdClr) | evts;

        // Read data, answered one cycle after the strobe
        st_d.rd = 32'h00000000;
        if (busReq.rd)
        begin
            case (busReq.addr)
                `APIO_ADR_STATUS:  st_d.rd[`APIO_NEVT-1:0] = st_q.status;
                `APIO_ADR_MASK:    st_d.rd[`APIO_NEVT-1:0] = st_q.mask;
                `APIO_ADR_COM:     st_d.rd = {16'h0000, {(8-NGEN){1'b0}}, st_q.comInv,
                                              {(8-NGEN){1'b0}}, st_q.comOut};
                `APIO_ADR_P2C:     st_d.rd = {16'h0000, {(8-NGEN){1'b0}}, st_q.p2Inv,
                                              {(8-NGEN){1'b0}}, st_q.p2Out};
                `APIO_ADR_OPT:     st_d.rd[1:0] = st_q.opt;
                `APIO_ADR_POS:     st_d.rd = {{(32-POS_W){st_q.pos[POS_W-1]}}, st_q.pos}; // [R15]
                `APIO_ADR_INPUTS:  st_d.rd[NGEN+2:0] = {pins.genIn, sensNow}; // [R1] [R2] [R3] [R4]
                `APIO_ADR_TRIGCNT: st_d.rd[7:0] = st_q.trigCount;
                `APIO_ADR_MOTION:  st_d.rd[3:0] = {motion.ccw, motion.pulse, motion.running,
                                                   motion.notArrived};
                default:           st_d.rd = 32'h00000000;
            endcase
        end

        // Output pins, registered
        for (int i = 0; i < NGEN; i++)
        begin
            st_d.outs.genOut[i] = altFuncSel[i] ? altFuncVal[i]
                                                : (st_q.comOut[i] ^ st_q.comInv[i]); // [R5]
        end
        st_d.outs.port2Out   = st_q.p2Out ^ st_q.p2Inv;                   // [R10]
        st_d.outs.dir        = motion.ccw ^ st_q.opt[`APIO_OPT_DIRINV];   // [R8]
        st_d.outs.stepPulse  = motion.running & motion.pulse;             // [R9]
        st_d.outs.notArrived = motion.notArrived;                         // [R11]
    end

    // Single state register; reset pin clears everything [R14]
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= '0;
            st_q.pos <= `APIO_POS_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pinsOut       = st_q.outs;
    assign rdData        = st_q.rd;
    assign syncTrigPulse = st_q.trigPulse;
    assign irq           = |(st_q.status & st_q.mask);

    // Each rising count edge moves position by exactly one in the pin's direction
    AST_COUNT_UP: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R7]
        (countEdge && !pins.countDir && !busReq.wr) |=> (st_q.pos == $past(st_q.pos) + 1'b1))
        else $error("Position did not add one on a low-direction edge");
    AST_COUNT_DN: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R7]
        (countEdge && pins.countDir) |=> (st_q.pos == $past(st_q.pos) - 1'b1))
        else $error("Position did not subtract one on a high-direction edge");
    AST_COUNT_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R6]
        (!countEdge && !busReq.wr) |=> $stable(st_q.pos))
        else $error("Position changed without a count edge");
    AST_TRIG_FALL: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R12]
        ($fell(syncVec[NSYNC-4])) |=> syncTrigPulse)
        else $error("Trigger falling edge not registered");
    AST_TRIG_ONE: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R12]
        syncTrigPulse |=> !syncTrigPulse)
        else $error("Trigger pulse longer than one cycle");
    AST_PULSE_STOP: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R9]
        (!motion.running) |=> !pinsOut.stepPulse)
        else $error("Pulse output high while stopped");
    AST_NOT_ARRIVED: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R11]
        ##1 (pinsOut.notArrived == $past(motion.notArrived)))
        else $error("Not-arrived output does not follow state");
    AST_DIR: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R8]
        ##1 (pinsOut.dir == ($past(motion.ccw) ^ $past(st_q.opt[`APIO_OPT_DIRINV]))))
        else $error("Direction output wrong");
    AST_PORT2: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R10]
        ##1 (pinsOut.port2Out == ($past(st_q.p2Out) ^ $past(st_q.p2Inv))))
        else $error("Port-2 output wrong");
    AST_GENOUT: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
        (altFuncSel == '0 && st_q.comInv == '0) |=> (pinsOut.genOut == $past(st_q.comOut)))
        else $error("General output does not follow command bits");
    AST_ORIGIN: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1]
        (busReq.rd && busReq.addr == `APIO_ADR_INPUTS) |=> (rdData[0] == !$past(syncVec[NSYNC-1])))
        else $error("Origin status not active-low");
    AST_LIMITS: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R2] [R3] [R4]
        (busReq.rd && busReq.addr == `APIO_ADR_INPUTS)
        |=> (rdData[NGEN+2:1] == ~{$past(syncVec[NGEN+2:3]), $past(syncVec[NSYNC-3]), $past(syncVec[NSYNC-2])}))
        else $error("Limit or general input status not active-low");
endmodule : apio_axis_pins

`default_nettype wire

// ### src/apio_map.svh
// Constants for the axis pin block: reset values, field positions, widths.
// Assumes inclusion by the package, the axis pin block and the bench top module.
`ifndef APIO_MAP_SVH
`define APIO_MAP_SVH

`define APIO_POS_W        24
`define APIO_POS_RST      24'h000000
`define APIO_NGEN         4
`define APIO_SYNC_STAGES  2
`define APIO_NEVT         6
`define APIO_EVT_ORIGIN   0
`define APIO_EVT_PLUS     1
`define APIO_EVT_MINUS    2
`define APIO_EVT_TRIG     3
`define APIO_EVT_WRAP     4
`define APIO_EVT_NOT_ARRIVED     5
`define APIO_ADDR_W       4
`define APIO_ADR_STATUS   4'h0
`define APIO_ADR_MASK     4'h1
`define APIO_ADR_COM      4'h2
`define APIO_ADR_P2C      4'h3
`define APIO_ADR_OPT      4'h4
`define APIO_ADR_POS      4'h5
`define APIO_ADR_INPUTS   4'h6
`define APIO_ADR_TRIGCNT  4'h7
`define APIO_ADR_MOTION   4'h8
`define APIO_OPT_DIRINV   0
`define APIO_OPT_CLRPOS   1

`endif

// ### src/apio_pkg.sv
// Types shared by the axis pin block.
// Assumes apio_map.svh is on the include path.
`include "apio_map.svh"

package apio_pkg;

    // Bus request from software
    typedef struct packed {
        logic [`APIO_ADDR_W-1:0] addr;
        logic [31:0]             wdata;
        logic                    wr;
        logic                    rd;
    } apio_bus_req_t;

    // Synchronised axis pins seen by the core
    typedef struct packed {
        logic                  origin;
        logic                  plusLimit;
        logic                  minusLimit;
        logic [`APIO_NGEN-1:0] genIn;
        logic                  countClk;
        logic                  countDir;
        logic                  trig;
    } apio_pins_t;

    // Motion core status driving the pulse and direction pins
    typedef struct packed {
        logic ccw;
        logic pulse;
        logic running;
        logic notArrived;
    } apio_motion_t;

    // Driven outputs
    typedef struct packed {
        logic [`APIO_NGEN-1:0] genOut;
        logic [`APIO_NGEN-1:0] port2Out;
        logic                  dir;
        logic                  stepPulse;
        logic                  notArrived;
    } apio_outs_t;

endpackage : apio_pkg

// ### src/apio_sync.sv
// Two-flop synchroniser bank for pins from outside the clock domain.
// Assumes sys_clk domain and asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module apio_sync #(
    parameter int                WIDTH = 8,
    parameter logic [WIDTH-1:0]  RST   = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } apio_sync_st_t;

    apio_sync_st_t st_q;
    apio_sync_st_t st_d;

    // First stage is read only by the second stage
    always_comb
    begin
        st_d.meta   = asyncIn;
        st_d.stable = st_q.meta;
    end

    // Reset to each pin's idle level given by RST so no false edge appears at release
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= '{meta: RST, stable: RST};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign syncOut = st_q.stable;
endmodule : apio_sync

`default_nettype wire

// ### bench/apio_axis_partner.sv
// Far side of the axis pins: sensors, encoder count lines and trigger source.
// Assumes the bench calls its tasks by hierarchical name and shares sys_clk.
`timescale 1ns/1ps
`default_nettype none

module apio_axis_partner (
    input  wire logic       sys_clk,
    output logic            origin_sensor_n,
    output logic            plus_limit_sensor_n,
    output logic            minus_limit_sensor_n,
    output logic [3:0]      axis_gen_input_n,
    output logic            position_count_clock,
    output logic            position_count_direction,
    output logic            sync_trigger_n
);
    // Sensors idle inactive (pulled high); count clock stands low between bursts
    initial
    begin
        {axis_gen_input_n, minus_limit_sensor_n, plus_limit_sensor_n, origin_sensor_n} = 7'h7f;
        position_count_clock = 1'b0;
        position_count_direction = 1'b0;
        sync_trigger_n = 1'b1;
    end

    // One bit per sensor: origin, plus, minus, then four general inputs; 1 pulls it low
    task automatic set_active(input logic [6:0] act);
        @(posedge sys_clk);
        {axis_gen_input_n, minus_limit_sensor_n, plus_limit_sensor_n, origin_sensor_n} <= ~act;
    endtask : set_active

    // Encoder burst; 3 cycles per phase keeps it above the 2-cycle minimum
    task automatic step(input int n, input logic down);
        @(posedge sys_clk);
        position_count_direction <= down;
        repeat (n)
        begin
            repeat (3) @(posedge sys_clk);
            position_count_clock <= 1'b1;
            repeat (3) @(posedge sys_clk);
            position_count_clock <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
    endtask : step

    // A trigger is the fall of this line; the bench chooses when it rises again
    task automatic set_trigger(input logic lvl);
        @(posedge sys_clk);
        sync_trigger_n <= lvl;
    endtask : set_trigger
endmodule : apio_axis_partner
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the axis pin block: register tasks and pin scenarios.
// Assumes apio_map.svh on the include path and the partner model on the pins.
`timescale 1ns/1ps
`default_nettype none
`include "apio_map.svh"

module tb_top;
    import apio_pkg::*;
    logic          sys_clk;
    logic          arst_n;
    apio_bus_req_t busReq;
    logic [31:0]   rdData;
    apio_motion_t  motion;
    logic [3:0]    altFuncSel;
    logic [3:0]    altFuncVal;
    apio_outs_t    pinsOut;
    logic          syncTrigPulse;
    logic          irq;
    wire logic     orgN, plusN, minusN, cntClk, cntDir, trigN;
    wire logic [3:0] genN;
    logic [31:0]   d;
    int            fails;
    int            n_checks;
    int            cycles;

    // 200 MHz clock
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    apio_axis_pins uut (.sys_clk(sys_clk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData),
        .origin_sensor_n(orgN), .plus_limit_sensor_n(plusN), .minus_limit_sensor_n(minusN),
        .axis_gen_input_n(genN), .position_count_clock(cntClk), .position_count_direction(cntDir),
        .sync_trigger_n(trigN), .motion(motion), .altFuncSel(altFuncSel), .altFuncVal(altFuncVal),
        .pinsOut(pinsOut), .syncTrigPulse(syncTrigPulse), .irq(irq));
    apio_axis_partner partner (.sys_clk(sys_clk), .origin_sensor_n(orgN), .plus_limit_sensor_n(plusN),
        .minus_limit_sensor_n(minusN), .axis_gen_input_n(genN), .position_count_clock(cntClk),
        .position_count_direction(cntDir), .sync_trigger_n(trigN));

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
    endtask : wr_reg

    // Data is taken only in the cycle after the strobe, and must be gone after it
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string name);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1 d = rdData;
        chk(name, e, d & m);
        settle(1);
        chk("rdData idle", 32'h0, rdData);
    endtask : rd_chk

    task automatic set_motion(input logic [3:0] m);
        @(posedge sys_clk);
        motion <= apio_motion_t'(m);
        settle(2);
    endtask : set_motion

    // Hang guard: the whole sequence needs a few hundred cycles
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            report_and_stop();
        end
    end

    initial
    begin
        fails = 0;
        n_checks = 0;
        arst_n = 1'b0;
        busReq = '0;
        motion = '0;
        altFuncSel = 4'h0;
        altFuncVal = 4'h0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        settle(1);
        chk("outs after reset", 32'h0, 32'(pinsOut));
        rd_chk(`APIO_ADR_POS, 32'hffffffff, 32'h0, "pos after reset");
        wr_reg(`APIO_ADR_MASK, 32'h3f);
        wr_reg(4'hf, 32'hffffffff);
        rd_chk(4'hf, 32'hffffffff, 32'h0, "unmapped");
        rd_chk(`APIO_ADR_MASK, 32'hffffffff, 32'h3f, "mask");
        // Walk one active sensor across every input status bit
        for (int i = 0; i < 7; i++)
        begin
            partner.set_active(7'h01 << i);
            settle(4);
            rd_chk(`APIO_ADR_INPUTS, 32'h7f, 32'h1 << i, "inputs");
        end
        partner.set_active(7'h00);
        settle(4);
        rd_chk(`APIO_ADR_INPUTS, 32'h7f, 32'h0, "inputs idle");
        rd_chk(`APIO_ADR_STATUS, 32'h0, 32'h0, "status clear");
        rd_chk(`APIO_ADR_STATUS, 32'h7, 32'h0, "status cleared");
        chk("irq idle", 32'h0, 32'(irq));
        partner.set_active(7'h01);
        settle(4);
        chk("irq origin", 32'h1, 32'(irq));
        rd_chk(`APIO_ADR_STATUS, 32'h1, 32'h1, "origin event");
        partner.set_active(7'h00);
        settle(4);
        rd_chk(`APIO_ADR_STATUS, 32'h0, 32'h0, "status clear");
        chk("irq cleared", 32'h0, 32'(irq));
        // Masked events stay sticky but keep the interrupt quiet
        wr_reg(`APIO_ADR_MASK, 32'h0);
        partner.set_active(7'h02);
        settle(4);
        chk("irq masked", 32'h0, 32'(irq));
        rd_chk(`APIO_ADR_STATUS, 32'h2, 32'h2, "plus event");
        partner.set_active(7'h04);
        settle(4);
        rd_chk(`APIO_ADR_STATUS, 32'h4, 32'h4, "minus event");
        partner.set_active(7'h00);
        // Output registers, with port 2 inverting its bit 0
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(`APIO_ADR_COM, 32'h1 << i);
            wr_reg(`APIO_ADR_P2C, 32'h100 | (32'h1 << i));
            settle(2);
            chk("genOut", 32'h1 << i, 32'(pinsOut.genOut));
            chk("port2Out", (32'h1 << i) ^ 32'h1, 32'(pinsOut.port2Out));
        end
        rd_chk(`APIO_ADR_P2C, 32'hffffffff, 32'h108, "p2c readback");
        // All four outputs inverted, alternate function on outputs 0 and 2
        @(posedge sys_clk);
        altFuncSel <= 4'h5;
        altFuncVal <= 4'h4;
        wr_reg(`APIO_ADR_COM, 32'h0f03);
        settle(2);
        chk("genOut alt", 32'hc, 32'(pinsOut.genOut));
        rd_chk(`APIO_ADR_COM, 32'hffffffff, 32'h0f03, "com readback");
        // One alternate function at a time: forces a one on outputs 0-1, a zero on 2-3
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            altFuncSel <= 4'h1 << i;
            altFuncVal <= (i < 2) ? 4'h1 << i : 4'h0;
            settle(2);
            chk("genOut alt", (i < 2) ? 32'hc | (32'h1 << i) : 32'hc & ~(32'h1 << i), 32'(pinsOut.genOut));
        end
        @(posedge sys_clk);
        altFuncSel <= 4'h0;
        set_motion(4'b1000);
        chk("dir ccw", 32'h1, 32'(pinsOut.dir));
        wr_reg(`APIO_ADR_OPT, 32'h1 << `APIO_OPT_DIRINV);
        settle(2);
        chk("dir inverted", 32'h0, 32'(pinsOut.dir));
        rd_chk(`APIO_ADR_OPT, 32'hffffffff, 32'h1, "opt readback");
        wr_reg(`APIO_ADR_OPT, 32'h0);
        set_motion(4'b0100);
        chk("pulse stopped", 32'h0, 32'(pinsOut.stepPulse));
        chk("dir cw", 32'h0, 32'(pinsOut.dir));
        set_motion(4'b0110);
        chk("pulse running", 32'h1, 32'(pinsOut.stepPulse));
        rd_chk(`APIO_ADR_MOTION, 32'hf, 32'h6, "motion readback");
        set_motion(4'b0001);
        chk("not arrived", 32'h1, 32'(pinsOut.notArrived));
        rd_chk(`APIO_ADR_STATUS, 32'h20, 32'h20, "not_arrived event");
        set_motion(4'b0000);
        chk("arrived", 32'h0, 32'(pinsOut.notArrived));
        // Counting both ways, then across both ends of the 24-bit range
        partner.step(5, 1'b0);
        rd_chk(`APIO_ADR_POS, 32'hffffffff, 32'h5, "pos up");
        partner.step(7, 1'b1);
        rd_chk(`APIO_ADR_POS, 32'hffffffff, 32'hfffffffe, "pos down");
        wr_reg(`APIO_ADR_POS, 32'h007fffff);
        partner.step(1, 1'b0);
        rd_chk(`APIO_ADR_POS, 32'hffffffff, 32'hff800000, "pos wrap");
        rd_chk(`APIO_ADR_STATUS, 32'h10, 32'h10, "wrap event");
        partner.step(1, 1'b1);
        rd_chk(`APIO_ADR_POS, 32'hffffffff, 32'h007fffff, "pos back");
        // Two triggers: each gives one pulse and one count
        for (int t = 1; t <= 2; t++)
        begin
            partner.set_trigger(1'b0);
            for (int k = 0; k < 8 && syncTrigPulse !== 1'b1; k++)
                settle(1);
            chk("trig pulse", 32'h1, 32'(syncTrigPulse));
            settle(1);
            chk("trig pulse end", 32'h0, 32'(syncTrigPulse));
            partner.set_trigger(1'b1);
            settle(4);
            rd_chk(`APIO_ADR_TRIGCNT, 32'hff, 32'(t), "trig count");
        end
        rd_chk(`APIO_ADR_STATUS, 32'h8, 32'h8, "trig event");
        // Reset in mid-run clears position and outputs
        wr_reg(`APIO_ADR_COM, 32'hf);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        settle(3);
        chk("outs in reset", 32'h0, 32'(pinsOut));
        @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk(`APIO_ADR_POS, 32'hffffffff, 32'h0, "pos reset");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
